// file: verilog/mcid_defines.vh
// register indices, field masks and fixed codes for the capability identification rom
`ifndef MCID_DEFINES_VH
`define MCID_DEFINES_VH
`define MCID_IDX_BASE_FIRST 8'h80
`define MCID_IDX_MAX_CASE_TEMP 8'hbe
`define MCID_IDX_BASE_CHECK 8'hbf
`define MCID_IDX_ETH_COMPLIANCE 8'hc0
`define MCID_IDX_OPT_POLARITY 8'hc1
`define MCID_IDX_OPT_CDR 8'hc2
`define MCID_IDX_OPT_PAGES 8'hc3
`define MCID_IDX_SERIAL_FIRST 8'hc4
`define MCID_IDX_SERIAL_LAST 8'hd3
`define MCID_IDX_DATE_FIRST 8'hd4
`define MCID_IDX_DATE_LAST 8'hdb
`define MCID_IDX_DIAG_TYPE 8'hdc
`define MCID_IDX_ENH_OPTIONS 8'hdd
`define MCID_IDX_BIT_RATE 8'hde
`define MCID_IDX_EXT_CHECK 8'hdf
`define MCID_IDX_EXT_FIRST 8'hc0
`define MCID_IDX_VENDOR_FIRST 8'he0
`define MCID_MASK_OPT_POLARITY 8'h3f
`define MCID_MASK_DIAG_TYPE 8'h7f
`define MCID_MASK_ENH_OPTIONS 8'hbf
`define MCID_ETH_LAST_DEFINED 8'h08
`define MCID_ETH_UNSPECIFIED 8'h00
`define MCID_ASCII_SPACE 8'h20
`define MCID_DEFAULT_CASE_TEMP 8'h46
`define MCID_SERIAL_LEN 16
`define MCID_VENDOR_LEN 32
`endif

// file: verilog/mcid_capability_rom.v
// read-only capability and identification byte region behind an apb slave
`timescale 1ns/1ps
// Behaviour
// - max case temperature byte, unsigned whole degrees, default 70
// - base check byte is low eight bits of sum of bytes 128..190
// - extended check byte is low bits of sum over bytes 192..222 plus FOLLOW_BYTE
// - byte 192 ethernet code; 01..08 defined, 09..ff reserved
// - byte 193 bits 7..6 reserved, bits 5..0 polarity/equalization/los options
// - byte 194 bits 7..0 cdr bypass, lol, squelch and output disable options
// - byte 195 page, rate select, tx disable, fault, los, rx squelch bits
// - byte 195 bit 2: 1 squelch lowers average power, 0 lowers modulation amplitude
// - serial field 16 ascii characters, left aligned, space padded on right
// - cable ends share serial, differ by -A/-B; octopus -C.., separable -T
// - date code: year, month, day, lot code, two ascii bytes each
// - byte 220 bit 7 reserved, temperature and per-channel monitor flags
// - byte 220 bit 3: 0 modulation amplitude, 1 average receive power
// - byte 221 bit 7 3.3 volt monitor, bit 6 reserved, bits 5..2 options
// - byte 221 bits 1..0 bit rate scale 250, 500, 1000 Mb/s, 2 Gb/s
// - byte 222 nominal per-channel bit rate in scale units
// - vendor specific area holds read-only vendor content
`include "mcid_defines.vh"

module mcid_capability_rom #(
	parameter ADDR_W = 12,
	parameter [7:0] MAX_CASE_TEMP = `MCID_DEFAULT_CASE_TEMP,
	parameter [7:0] LOWER_BYTES_SUM = 8'h00,
	parameter [7:0] ETH_COMPLIANCE = 8'h02,
	parameter [7:0] OPT_POLARITY = 8'h00,
	parameter [7:0] OPT_CDR = 8'h00,
	parameter [7:0] OPT_PAGES = 8'h00,
	parameter [127:0] SERIAL = "UNIT0001-A",
	parameter [63:0] DATE_CODE = "000101  ",
	parameter [7:0] DIAG_TYPE = 8'h00,
	parameter [7:0] ENH_OPTIONS = 8'h00,
	parameter [7:0] BIT_RATE = 8'h00,
	parameter [7:0] FOLLOW_BYTE = 8'h00,
	parameter [255:0] VENDOR_AREA = 256'h0
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr
);

	// left aligned ascii: trailing nul characters become spaces
	function [127:0] pad_serial;
		input [127:0] raw;
		integer i;
		reg tail;
		begin
			pad_serial = raw;
			tail = 1'b1;
			// the string literal is right aligned in the vector, so shift out leading nul bytes first
			for (i = 0; i < `MCID_SERIAL_LEN; i = i + 1) begin
				if (pad_serial[127:120] == 8'h00 && pad_serial != 128'h0)
					pad_serial = {pad_serial[119:0], 8'h00};
			end
			for (i = 0; i < `MCID_SERIAL_LEN; i = i + 1) begin
				if (tail && pad_serial[i*8 +: 8] == 8'h00)
					pad_serial[i*8 +: 8] = `MCID_ASCII_SPACE;
				else
					tail = 1'b0;
			end
		end
	endfunction

	// reserved compliance codes are reported as unspecified
	function [7:0] clean_compliance;
		input [7:0] code;
		begin
			if (code > `MCID_ETH_LAST_DEFINED)
				clean_compliance = `MCID_ETH_UNSPECIFIED;
			else
				clean_compliance = code;
		end
	endfunction

	localparam [127:0] SERIAL_PADDED = pad_serial(SERIAL);
	localparam [7:0] ETH_CODE = clean_compliance(ETH_COMPLIANCE);

	// stored content byte, check codes excluded; first character sits at the lowest index
	function [7:0] content_byte;
		input [7:0] idx;
		reg [7:0] off;
		begin
			content_byte = 8'h00;
			off = 8'h00;
			if (idx == `MCID_IDX_MAX_CASE_TEMP)
				content_byte = MAX_CASE_TEMP;
			else if (idx == `MCID_IDX_ETH_COMPLIANCE)
				content_byte = ETH_CODE;
			else if (idx == `MCID_IDX_OPT_POLARITY)
				content_byte = OPT_POLARITY & `MCID_MASK_OPT_POLARITY;
			else if (idx == `MCID_IDX_OPT_CDR)
				content_byte = OPT_CDR;
			else if (idx == `MCID_IDX_OPT_PAGES)
				content_byte = OPT_PAGES;
			else if (idx >= `MCID_IDX_SERIAL_FIRST && idx <= `MCID_IDX_SERIAL_LAST) begin
				off = idx - `MCID_IDX_SERIAL_FIRST;
				content_byte = SERIAL_PADDED[(15 - off[3:0])*8 +: 8];
			end else if (idx >= `MCID_IDX_DATE_FIRST && idx <= `MCID_IDX_DATE_LAST) begin
				off = idx - `MCID_IDX_DATE_FIRST;
				content_byte = DATE_CODE[(7 - off[2:0])*8 +: 8];
			end else if (idx == `MCID_IDX_DIAG_TYPE)
				content_byte = DIAG_TYPE & `MCID_MASK_DIAG_TYPE;
			else if (idx == `MCID_IDX_ENH_OPTIONS)
				content_byte = ENH_OPTIONS & `MCID_MASK_ENH_OPTIONS;
			else if (idx == `MCID_IDX_BIT_RATE)
				content_byte = BIT_RATE;
			else if (idx >= `MCID_IDX_VENDOR_FIRST) begin
				off = idx - `MCID_IDX_VENDOR_FIRST;
				content_byte = VENDOR_AREA[off[4:0]*8 +: 8];
			end
		end
	endfunction

	// sum of a run of content bytes, carried in eight bits so only the low byte survives
	function [7:0] sum_range;
		input [7:0] first;
		input [7:0] last;
		integer i;
		begin
			sum_range = 8'h00;
			for (i = 128; i < 256; i = i + 1) begin
				if (i >= first && i <= last)
					sum_range = sum_range + content_byte(i[7:0]);
			end
		end
	endfunction

	// bytes 128..189 live outside this block, so their sum arrives as a parameter
	localparam [7:0] BASE_CHECK = LOWER_BYTES_SUM + MAX_CASE_TEMP;
	// the code byte cannot sum itself; it covers 192..222 plus the following byte
	localparam [7:0] EXT_CHECK = sum_range(`MCID_IDX_EXT_FIRST, `MCID_IDX_BIT_RATE) + FOLLOW_BYTE;

	wire [7:0] idx;
	wire in_range;
	wire mapped;
	reg [7:0] next_byte;

	assign idx = paddr[9:2];
	// only aligned word addresses in the lowest 1024 bytes are ours
	assign in_range = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}});
	assign mapped = in_range && (idx >= `MCID_IDX_MAX_CASE_TEMP);

	// read mux: unmapped reads give zero, check codes come from the folded constants, the rest from content
	always @* begin
		if (!mapped)
			next_byte = 8'h00;
		else if (idx == `MCID_IDX_BASE_CHECK)
			next_byte = BASE_CHECK;
		else if (idx == `MCID_IDX_EXT_CHECK)
			next_byte = EXT_CHECK;
		else
			next_byte = content_byte(idx);
	end

	// one wait-free access: answer is prepared in the setup cycle and shown in the access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pready <= 1'b1;
			// writes are refused with an error and never touch the contents
			pslverr <= pwrite || !mapped;
			prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_byte};
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
	end

endmodule // mcid_capability_rom

// file: tb/mcid_monitor.sv
// assertion checker bound to the capability rom apb port
`timescale 1ns/1ps
module mcid_monitor #(parameter ADDR_W = 12) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb request
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	// apb answer
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// read setup at an aligned word inside the page; misaligned ones are refused elsewhere
	wire rd = psel && !penable && !pwrite && paddr[1:0] == 2'b00 && paddr[ADDR_W-1:10] == 2'b00;
	wire [7:0] ix = paddr[9:2];
	wire [7:0] b = prdata[7:0];
	property p_pulse; psel && !penable |=> pready ##1 !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready not one pulse");
	property p_wr; psel && !penable && pwrite |=> pslverr && ~|prdata; endproperty
	a_wr: assert property (p_wr) else $error("write not refused");
	property p_upper; pready |-> prdata[31:8] == 24'h00_0000; endproperty
	a_upper: assert property (p_upper) else $error("upper bits set");
	property p_eth; rd && ix == 8'hc0 |=> b <= 8'h08; endproperty
	a_eth: assert property (p_eth) else $error("reserved code");
	property p_opt; rd && ix == 8'hc1 |=> b[7:6] == 2'b00; endproperty
	a_opt: assert property (p_opt) else $error("reserved bits set");
	property p_sn; rd && ix inside {[8'hc4:8'hd3]} |=> b inside {[8'h20:8'h7e]}; endproperty
	a_sn: assert property (p_sn) else $error("serial not ascii");
	property p_date; rd && ix inside {[8'hd4:8'hdb]} |=> b inside {8'h20, [8'h30:8'h39]}; endproperty
	a_date: assert property (p_date) else $error("date not digits");
	property p_diag; rd && ix == 8'hdc |=> !b[7]; endproperty
	a_diag: assert property (p_diag) else $error("reserved bit set");
endmodule // mcid_monitor

bind mcid_capability_rom mcid_monitor #(.ADDR_W(ADDR_W)) u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// file: tb/mcid_host.sv
// apb host model issuing transfers to the rom
`timescale 1ns/1ps
module mcid_host (
	// clock
	input wire pclk,
	// apb master side
	output logic psel = 1'b0,
	output logic penable = 1'b0,
	output logic pwrite = 1'b0,
	output logic [11:0] paddr = 12'h000,
	output logic [31:0] pwdata = 32'h0000_0000,
	output logic [3:0] pstrb = 4'h0,
	input wire pready
);
	bit hang = 1'b0;
	// psel stays up so calls run back to back; the wait is bounded so a dead slave ends the run
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= wr ? d[3:0] : 4'h0;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		hang = n >= 16;
	endtask
	// called right after the last completing edge: drop the request so the bus goes idle
	task automatic release_bus;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // mcid_host

// file: tb/mcid_capability_rom_test.sv
// self-checking bench for the capability rom
`timescale 1ns/1ps
module mcid_capability_rom_test;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	wire psel, penable, pwrite, pready, pslverr;
	wire [11:0] paddr;
	wire [31:0] pwdata, prdata;
	wire [3:0] pstrb;
	logic [7:0] e [0:255];
	logic [32:0] q [$];
	int bad_count = 0;
	int samples_checked = 0;
	int seed = 32'hf12f16bc;
	initial forever #50 pclk = ~pclk;
	mcid_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready));
	// the masked and cleaned fields and the vendor area are overridden; the rest keep their defaults
	mcid_capability_rom #(.ETH_COMPLIANCE(8'h09), .OPT_POLARITY(8'hff), .DIAG_TYPE(8'hff),
		.ENH_OPTIONS(8'hff), .VENDOR_AREA({32{8'h5a}})) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	task check(input logic [32:0] seen, input logic [32:0] want);
		samples_checked++;
		if (seen !== want) begin
			bad_count++;
			$display("wrong value at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	// each answer against the oldest expectation
	always @(posedge pclk) begin
		if (pready === 1'b1) check({pslverr, prdata}, q.size() ? q.pop_front() : 33'h1_dead_beef);
	end
	task tally_and_finish;
		bad_count += q.size() + host.hang;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task go(input logic wr, input logic [11:0] a, input logic [32:0] want);
		q.push_back(want);
		host.xfer(wr, a, $random(seed));
		if (host.hang) tally_and_finish();
	endtask
	initial begin
		for (int i = 0; i < 256; i++) e[i] = 8'h5a;
		e[8'hbe] = 8'h46;
		e[8'hc0] = 8'h00;
		e[8'hc1] = 8'h3f;
		e[8'hc2] = 8'h00;
		e[8'hc3] = 8'h00;
		for (int k = 0; k < 16; k++) e[8'hc4 + k] = "UNIT0001-A      " >> (120 - 8 * k);
		for (int k = 0; k < 8; k++) e[8'hd4 + k] = "000101  " >> (56 - 8 * k);
		e[8'hdc] = 8'h7f;
		e[8'hdd] = 8'hbf;
		e[8'hde] = 8'h00;
		e[8'hbf] = 8'h00 + 8'h46;
		e[8'hdf] = 8'h00;
		for (int i = 8'hc0; i < 8'hdf; i++) e[8'hdf] += e[i];
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// read all, write all with random data, read all again; back to back throughout
		for (int p = 0; p < 3; p++)
			for (int i = 8'hbe; i < 256; i++) go(p == 1, 12'(i * 4), p == 1 ? 33'h1_0000_0000 : {25'h0, e[i]});
		go(1'b0, 12'h2f4, 33'h1_0000_0000);
		go(1'b0, 12'h2f9, 33'h1_0000_0000);
		go(1'b0, 12'h6f8, 33'h1_0000_0000);
		host.release_bus();
		repeat (3) @(posedge pclk);
		tally_and_finish();
	end
endmodule // mcid_capability_rom_test
